// [inc/rbcs_params.svh]
// Timing counts, reset values and field positions of the reset sequencer.
`ifndef RBCS_PARAMS_SVH
`define RBCS_PARAMS_SVH
`define RBCS_CLK_PERIOD_PS 5000
`define RBCS_WD_PULSE_CYC 512
`define RBCS_BUS_VALID_CYC 32
`define RBCS_STRAP_HOLD_CYC 16
`define RBCS_BOOT_SYS_CYC 1260
`define RBCS_PLL_LOCK_CYC 131072
`define RBCS_XTIM_RST 1'h1
`define RBCS_EXT_CLOCK_OUTPUT_DIVIDE_RST 1'h1
`define RBCS_PLLMUL_RST 4'h0
`define RBCS_CFG_XTIM_BIT 0
`define RBCS_CFG_EXT_CLOCK_OUTPUT_DIVIDE_BIT 1
`endif

// [inc/rbcs_pkg.sv]
// Types shared by the reset and boot clock sequencer.
package rbcs_pkg;
   typedef enum logic [2:0] {
      RBCS_ST_RESET = 3'h0,
      RBCS_ST_STRAP = 3'h1,
      RBCS_ST_BUS_WAIT = 3'h3,
      RBCS_ST_BOOT = 3'h2,
      RBCS_ST_RUN = 3'h6,
      RBCS_ST_WDOG = 3'h7
   } rbcs_state_t;

   typedef enum logic [1:0] {
      RBCS_CLK_DIRECT = 2'h0,
      RBCS_CLK_HALF = 2'h1,
      RBCS_CLK_PLL = 2'h2
   } rbcs_clk_src_t;

   typedef struct packed {
      logic ext_timing_clock_divide;
      logic ext_clock_output_divide;
   } rbcs_ext_cfg_t;

   typedef struct packed {
      rbcs_clk_src_t src;
      logic [3:0] pll_mul;
      logic pll_locked;
   } rbcs_clk_sel_t;
endpackage

// [verilog/rbcs_sequencer.sv]
// Reset, strap sampling, boot delay and clock selection sequencer.
`timescale 1ns/1ps
`include "rbcs_params.svh"
module rbcs_sequencer
   import rbcs_pkg::*;
#(
   parameter int unsigned BOOT_W = 4,
   parameter int unsigned PLL_LOCK_CYC = `RBCS_PLL_LOCK_CYC
) (
   input wire logic clk_sys_i, // Input clock, 200 MHz.
   input wire logic arst_n_i, // Power-on reset, active low.
   input wire logic device_reset_pin_n_i, // Board reset pin, active low.
   input wire logic wdog_req_i, // Watchdog reset request pulse.
   input wire logic pll_disable_strap_n_i, // Low disables the PLL.
   input wire logic processor_mode_strap_i, // Mode strap.
   input wire logic [BOOT_W-1:0] boot_mode_i, // Boot-mode pins.
   input wire logic [7:0] cfg_addr_i, // Register address.
   input wire logic [31:0] cfg_wdata_i, // Register write data.
   input wire logic cfg_wr_i, // Register write strobe.
   input wire logic cfg_rd_i, // Register read strobe.
   output logic [31:0] cfg_rdata_o, // Read data, cycle after strobe.
   output logic reset_out_n_o, // Device reset output, active low.
   output logic core_reset_n_o, // Core held in reset while low.
   output logic bus_valid_o, // External bus address/data valid.
   output logic boot_taken_o, // Boot-mode pins have been sampled.
   output logic [BOOT_W-1:0] boot_sel_o, // Sampled boot selection.
   output logic processor_mode_o, // Sampled processor mode.
   output rbcs_ext_cfg_t ext_cfg_o, // Clock-output divide bits.
   output logic [2:0] clkout_div_log2_o, // Log2 of input to clock-out ratio.
   output rbcs_clk_sel_t clk_sel_o // System clock source and multiplier.
);
   localparam logic [7:0] ADDR_EXT_CFG = 8'h00;
   localparam logic [7:0] ADDR_PLL_MUL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int unsigned CNT_W = 18;
   localparam int unsigned BOOT_XCLK = 2 * `RBCS_BOOT_SYS_CYC;
   // Straps are taken halfway through their hold, so the synchroniser lag
   // still lands the sample inside the window that the board guarantees.
   localparam int unsigned STRAP_TAKE = `RBCS_STRAP_HOLD_CYC / 2;
   // Boot pins are captured between these counts before the end of the
   // boot delay, which covers the three stage synchroniser delay.
   localparam logic [CNT_W-1:0] BOOT_LEAD = 18'h8;
   localparam logic [CNT_W-1:0] BOOT_LAST = 18'h3;

   initial begin
      if (BOOT_W < 1 || BOOT_W > 8) begin
         $error("BOOT_W out of range");
      end
      if (PLL_LOCK_CYC < 1 || PLL_LOCK_CYC >= (1 << CNT_W)) begin
         $error("PLL_LOCK_CYC does not fit the counter");
      end
   end

   typedef struct packed {
      logic [2:0] pin_sync;
      logic [2:0] pll_sync;
      logic [2:0] mode_sync;
      logic pin_low;
      logic pll_dis_n;
      rbcs_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] lock_cnt;
      logic pll_dis;
      logic proc_mode;
      logic [BOOT_W-1:0] boot_sel;
      logic boot_taken;
      logic [BOOT_W-1:0] boot_cap;
      logic boot_held;
      logic bus_valid;
      logic rst_out_n;
      rbcs_ext_cfg_t ext_cfg;
      logic [3:0] pll_mul;
      logic locked;
      logic [31:0] rdata;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   logic [BOOT_W-1:0] boot_s1_ff;
   logic [BOOT_W-1:0] boot_s2_ff;
   logic [BOOT_W-1:0] boot_s3_ff;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = CNT_W'(n - 1);
   endfunction

   function automatic logic stable(input logic [2:0] s);
      stable = (s[1] == s[2]);
   endfunction

   // Boot pins pass the same three stage synchroniser as the other pins.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_s1_ff <= '0;
         boot_s2_ff <= '0;
         boot_s3_ff <= '0;
      end else begin
         boot_s1_ff <= boot_mode_i;
         boot_s2_ff <= boot_s1_ff;
         boot_s3_ff <= boot_s2_ff;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_sync = {st_ff.pin_sync[1:0], ~device_reset_pin_n_i};
      nxt_st.pll_sync = {st_ff.pll_sync[1:0], pll_disable_strap_n_i};
      nxt_st.mode_sync = {st_ff.mode_sync[1:0], processor_mode_strap_i};
      if (stable(st_ff.pin_sync)) begin
         nxt_st.pin_low = st_ff.pin_sync[2];
      end
      if (stable(st_ff.pll_sync)) begin
         nxt_st.pll_dis_n = st_ff.pll_sync[2];
      end
      nxt_st.rdata = '0;
      if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      if (st_ff.lock_cnt != '0) begin
         nxt_st.lock_cnt = st_ff.lock_cnt - 1'b1;
      end else begin
         nxt_st.locked = 1'b1;
      end

      unique case (st_ff.st)
         RBCS_ST_RESET: begin
            nxt_st.cnt = cyc(STRAP_TAKE);
            if (!st_ff.pin_low) begin
               nxt_st.st = RBCS_ST_STRAP;
            end
         end
         RBCS_ST_STRAP: begin
            // Straps are taken halfway through their hold window.
            if (st_ff.cnt == '0) begin
               nxt_st.pll_dis = ~st_ff.pll_dis_n;
               if (stable(st_ff.mode_sync)) begin
                  nxt_st.proc_mode = st_ff.mode_sync[2];
               end
               nxt_st.cnt = cyc(`RBCS_BUS_VALID_CYC - STRAP_TAKE);
               nxt_st.st = RBCS_ST_BUS_WAIT;
            end
         end
         RBCS_ST_BUS_WAIT: begin
            if (st_ff.cnt == '0) begin
               nxt_st.bus_valid = 1'b1;
               nxt_st.boot_held = 1'b0;
               nxt_st.cnt = cyc(BOOT_XCLK - `RBCS_BUS_VALID_CYC);
               nxt_st.st = RBCS_ST_BOOT;
            end
         end
         RBCS_ST_BOOT: begin
            // Boot delay counts input clocks, two for each system clock at half the input clock.
            // The pins are captured a few clocks before the end, once two
            // synchroniser stages agree, so the synchroniser lag still puts
            // the sample inside the time that the board holds them.
            if (!st_ff.boot_held && st_ff.cnt <= BOOT_LEAD &&
                (boot_s2_ff == boot_s3_ff || st_ff.cnt == BOOT_LAST)) begin
               nxt_st.boot_cap = boot_s3_ff;
               nxt_st.boot_held = 1'b1;
            end
            if (st_ff.cnt == '0) begin
               nxt_st.boot_sel = st_ff.boot_cap;
               nxt_st.boot_taken = 1'b1;
               nxt_st.st = RBCS_ST_RUN;
            end
         end
         RBCS_ST_RUN: begin
         end
         RBCS_ST_WDOG: begin
            if (st_ff.cnt == '0) begin
               nxt_st.rst_out_n = 1'b1;
               nxt_st.st = RBCS_ST_RESET;
            end
         end
         default: begin
            nxt_st.st = RBCS_ST_RESET;
         end
      endcase

      if (st_ff.st != RBCS_ST_RESET && st_ff.st != RBCS_ST_WDOG &&
          cfg_wr_i) begin
         if (cfg_addr_i == ADDR_EXT_CFG) begin
            nxt_st.ext_cfg.ext_timing_clock_divide =
               cfg_wdata_i[`RBCS_CFG_XTIM_BIT];
            nxt_st.ext_cfg.ext_clock_output_divide =
               cfg_wdata_i[`RBCS_CFG_EXT_CLOCK_OUTPUT_DIVIDE_BIT];
         end else if (cfg_addr_i == ADDR_PLL_MUL && !st_ff.pll_dis) begin
            nxt_st.pll_mul = cfg_wdata_i[3:0];
            if (cfg_wdata_i[3:0] != st_ff.pll_mul) begin
               nxt_st.locked = 1'b0;
               nxt_st.lock_cnt = cyc(PLL_LOCK_CYC);
            end
         end
      end
      if (cfg_rd_i) begin
         unique case (cfg_addr_i)
            ADDR_EXT_CFG: nxt_st.rdata = {30'h0,
               st_ff.ext_cfg.ext_clock_output_divide,
               st_ff.ext_cfg.ext_timing_clock_divide};
            ADDR_PLL_MUL: nxt_st.rdata = {28'h0, st_ff.pll_mul};
            ADDR_STATUS: nxt_st.rdata = {16'h0, 8'(st_ff.boot_sel),
               2'h0, st_ff.locked, st_ff.pll_dis, st_ff.proc_mode,
               st_ff.boot_taken, st_ff.bus_valid, st_ff.rst_out_n};
            default: nxt_st.rdata = '0;
         endcase
      end

      // Pin reset and watchdog both restart the whole sequence.
      // A pin reset in mid pulse lets the watchdog pulse run out first,
      // otherwise the reset output would never be released.
      if (st_ff.pin_low && st_ff.st != RBCS_ST_WDOG) begin
         nxt_st.st = RBCS_ST_RESET;
      end
      if (st_ff.pin_low || (wdog_req_i && st_ff.st != RBCS_ST_WDOG)) begin
         nxt_st.bus_valid = 1'b0;
         nxt_st.boot_taken = 1'b0;
         nxt_st.boot_sel = '0;
         nxt_st.boot_held = 1'b0;
         nxt_st.ext_cfg.ext_timing_clock_divide = `RBCS_XTIM_RST;
         nxt_st.ext_cfg.ext_clock_output_divide = `RBCS_EXT_CLOCK_OUTPUT_DIVIDE_RST;
         nxt_st.pll_mul = `RBCS_PLLMUL_RST;
         nxt_st.lock_cnt = '0;
         nxt_st.locked = 1'b1;
      end
      if (wdog_req_i && !st_ff.pin_low && st_ff.st != RBCS_ST_WDOG) begin
         nxt_st.rst_out_n = 1'b0;
         nxt_st.cnt = cyc(`RBCS_WD_PULSE_CYC);
         nxt_st.st = RBCS_ST_WDOG;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= '0;
         st_ff.pin_sync <= 3'h7;
         st_ff.pll_sync <= 3'h7;
         st_ff.pin_low <= 1'b1;
         st_ff.pll_dis_n <= 1'b1;
         st_ff.st <= RBCS_ST_RESET;
         st_ff.rst_out_n <= 1'b1;
         st_ff.ext_cfg <= {`RBCS_XTIM_RST, `RBCS_EXT_CLOCK_OUTPUT_DIVIDE_RST};
         st_ff.pll_mul <= `RBCS_PLLMUL_RST;
         st_ff.locked <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      clk_sel_o.pll_mul = st_ff.pll_mul;
      clk_sel_o.pll_locked = st_ff.locked;
      if (st_ff.pll_dis) begin
         clk_sel_o.src = RBCS_CLK_DIRECT;
      end else if (st_ff.pll_mul != '0 && st_ff.locked) begin
         clk_sel_o.src = RBCS_CLK_PLL;
      end else begin
         clk_sel_o.src = RBCS_CLK_HALF;
      end
   end

   // Ratio of input clock to clock-out: system ratio plus 2 when both set.
   always_comb begin
      logic [2:0] sys_l2;
      sys_l2 = (clk_sel_o.src == RBCS_CLK_DIRECT) ? 3'h0 : 3'h1;
      if (st_ff.ext_cfg.ext_timing_clock_divide &&
          st_ff.ext_cfg.ext_clock_output_divide) begin
         clkout_div_log2_o = sys_l2 + 3'h2;
      end else if (st_ff.ext_cfg.ext_timing_clock_divide ||
                   st_ff.ext_cfg.ext_clock_output_divide) begin
         clkout_div_log2_o = sys_l2 + 3'h1;
      end else begin
         clkout_div_log2_o = sys_l2;
      end
   end

   assign cfg_rdata_o = st_ff.rdata;
   assign reset_out_n_o = st_ff.rst_out_n;
   assign core_reset_n_o = st_ff.bus_valid;
   assign bus_valid_o = st_ff.bus_valid;
   assign boot_taken_o = st_ff.boot_taken;
   assign boot_sel_o = st_ff.boot_sel;
   assign processor_mode_o = st_ff.proc_mode;
   assign ext_cfg_o = st_ff.ext_cfg;
endmodule

// [verif/rbcs_seq_checker.sv]
// Port-level assertions for the reset and boot clock sequencer.
`timescale 1ns/1ps
`include "rbcs_params.svh"
module rbcs_seq_checker
   import rbcs_pkg::*;
#(
   parameter int unsigned BOOT_W = 4,
   parameter int unsigned PLL_LOCK_CYC = `RBCS_PLL_LOCK_CYC
) (
   input wire logic clk_sys_i, // Clock.
   input wire logic arst_n_i, // Reset.
   input wire logic device_reset_pin_n_i, // Pin.
   input wire logic wdog_req_i, // Watchdog.
   input wire logic reset_out_n_o, // Reset out.
   input wire logic core_reset_n_o, // Core reset.
   input wire logic bus_valid_o, // Bus valid.
   input wire logic boot_taken_o, // Boot taken.
   input wire rbcs_ext_cfg_t ext_cfg_o, // Divide bits.
   input wire logic [2:0] clkout_div_log2_o, // Ratio.
   input wire rbcs_clk_sel_t clk_sel_o // Clock select.
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic [11:0] lo_ff;
   logic [11:0] hi_ff;
   logic [31:0] mc_ff;
   logic [3:0] mul_ff;
   // Release delays are measured from the pin or the watchdog pulse end.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lo_ff <= 12'h000;
         hi_ff <= 12'h000;
         mc_ff <= 32'h0;
         mul_ff <= 4'h0;
      end else begin
         lo_ff <= reset_out_n_o ? 12'h000 : lo_ff + 12'h001;
         hi_ff <= (device_reset_pin_n_i && reset_out_n_o) ? hi_ff + 12'h001
            : 12'h000;
         mul_ff <= clk_sel_o.pll_mul;
         mc_ff <= (clk_sel_o.pll_mul != mul_ff) ? 32'h0 : mc_ff + 32'h1;
      end
   end
   property p_wd_len;
      $rose(reset_out_n_o) |-> lo_ff == 12'h200;
   endproperty
   a_wd_len: assert property (p_wd_len) else $error("watchdog pulse");
   property p_wd_go;
      wdog_req_i && reset_out_n_o && bus_valid_o |=>
         !reset_out_n_o && !bus_valid_o && !boot_taken_o;
   endproperty
   a_wd_go: assert property (p_wd_go) else $error("watchdog start");
   property p_bus;
      $rose(bus_valid_o) |-> hi_ff >= 12'h020 && hi_ff <= 12'h028;
   endproperty
   a_bus: assert property (p_bus) else $error("bus valid delay");
   property p_core;
      core_reset_n_o == bus_valid_o;
   endproperty
   a_core: assert property (p_core) else $error("core reset");
   property p_boot;
      $rose(boot_taken_o) |-> hi_ff >= 12'h9D8 && hi_ff <= 12'h9E0;
   endproperty
   a_boot: assert property (p_boot) else $error("boot delay");
   property p_cfg;
      $rose(bus_valid_o) |-> ext_cfg_o == 2'h3 &&
         clk_sel_o.src != RBCS_CLK_PLL;
   endproperty
   a_cfg: assert property (p_cfg) else $error("reset config");
   property p_div;
      clk_sel_o.src != RBCS_CLK_PLL |-> clkout_div_log2_o ==
         3'(ext_cfg_o.ext_timing_clock_divide) +
         3'(ext_cfg_o.ext_clock_output_divide) +
         3'(clk_sel_o.src == RBCS_CLK_HALF);
   endproperty
   a_div: assert property (p_div) else $error("clock out ratio");
   property p_pll;
      clk_sel_o.src == RBCS_CLK_PLL |->
         clk_sel_o.pll_locked && clk_sel_o.pll_mul != 4'h0;
   endproperty
   a_pll: assert property (p_pll) else $error("pll source");
   property p_lock;
      $rose(clk_sel_o.pll_locked) && clk_sel_o.pll_mul != 4'h0 |->
         mc_ff + 2 >= PLL_LOCK_CYC && mc_ff <= PLL_LOCK_CYC + 2;
   endproperty
   a_lock: assert property (p_lock) else $error("pll lock wait");
   c_wd: cover property ($rose(reset_out_n_o));
   c_boot: cover property ($rose(boot_taken_o));
   c_pll: cover property (clk_sel_o.src == RBCS_CLK_PLL);
endmodule
bind rbcs_sequencer rbcs_seq_checker #(.BOOT_W(BOOT_W),
   .PLL_LOCK_CYC(PLL_LOCK_CYC)) u_chk (.clk_sys_i, .arst_n_i,
   .device_reset_pin_n_i, .wdog_req_i, .reset_out_n_o, .core_reset_n_o,
   .bus_valid_o, .boot_taken_o, .ext_cfg_o, .clkout_div_log2_o, .clk_sel_o);

// [verif/rbcs_board.sv]
// Board reset supervisor and strap drivers facing the sequencer.
`timescale 1ns/1ps
module rbcs_board #(
   parameter int unsigned BOOT_W = 4
) (
   input wire logic clk_sys_i, // Clock.
   input wire logic go_i, // Start a reset pulse.
   input wire logic wd_n_i, // Device reset output.
   input wire logic pll_i, // Chosen PLL strap.
   input wire logic mode_i, // Chosen mode strap.
   input wire logic [BOOT_W-1:0] boot_i, // Chosen boot pins.
   output logic pin_n_o, // Reset pin.
   output logic pll_o, // PLL strap pin.
   output logic mode_o, // Mode strap pin.
   output logic [BOOT_W-1:0] boot_o // Boot pins.
);
   int unsigned cnt = 0;
   int unsigned rel = 0;
   always_ff @(posedge clk_sys_i) begin
      cnt <= go_i ? 0 : cnt + 1;
      rel <= (!pin_n_o || !wd_n_i) ? 0 : rel + 1;
   end
   // Low 24 clocks from time zero or a request, so straps get 16 setup.
   assign pin_n_o = cnt >= 24;
   // Straps flip once their hold ends, so a late sample reads wrong.
   assign pll_o = rel < 17 ? pll_i : !pll_i;
   assign mode_o = rel < 17 ? mode_i : !mode_i;
   assign boot_o = rel < 2521 ? boot_i : ~boot_i;
endmodule

// [verif/rbcs_sequencer_test.sv]
// Directed bench for the reset and boot clock sequencer.
`timescale 1ns/1ps
module rbcs_sequencer_test;
   import rbcs_pkg::*;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic wdog_req_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00;
   logic [31:0] cfg_wdata_i = 32'h0;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic go = 1'b0;
   logic pll = 1'b1;
   logic mode = 1'b1;
   logic [3:0] boot = 4'hA;
   logic pin_n, pll_s, mode_s, rst_o, core_o, bus_o, taken_o, mode_o;
   logic [3:0] boot_s, sel_o;
   logic [31:0] rdata, rd_q;
   rbcs_ext_cfg_t ext_o;
   logic [2:0] log2_o;
   rbcs_clk_sel_t sel;
   int bad_count = 0;
   int comparisons = 0;
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   rbcs_sequencer #(.BOOT_W(4), .PLL_LOCK_CYC(50)) DUT (.clk_sys_i,
      .arst_n_i, .device_reset_pin_n_i(pin_n), .wdog_req_i,
      .pll_disable_strap_n_i(pll_s), .processor_mode_strap_i(mode_s),
      .boot_mode_i(boot_s), .cfg_addr_i, .cfg_wdata_i, .cfg_wr_i, .cfg_rd_i,
      .cfg_rdata_o(rdata), .reset_out_n_o(rst_o), .core_reset_n_o(core_o),
      .bus_valid_o(bus_o), .boot_taken_o(taken_o), .boot_sel_o(sel_o),
      .processor_mode_o(mode_o), .ext_cfg_o(ext_o),
      .clkout_div_log2_o(log2_o), .clk_sel_o(sel));
   rbcs_board #(.BOOT_W(4)) u_board (.clk_sys_i, .go_i(go), .wd_n_i(rst_o),
      .pll_i(pll), .mode_i(mode), .boot_i(boot), .pin_n_o(pin_n),
      .pll_o(pll_s), .mode_o(mode_s), .boot_o(boot_s));
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      cfg_addr_i <= a;
      cfg_wdata_i <= d;
      cfg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      cfg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      cfg_addr_i <= a;
      cfg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      cfg_rd_i <= 1'b0;
      #1;
      rd_q = rdata;
   endtask
   function automatic logic sig(input int s);
      return s == 0 ? bus_o : s == 1 ? taken_o : s == 2 ? rst_o :
         s == 3 ? sel.src == RBCS_CLK_PLL : !bus_o;
   endfunction
   // Waits are bounded so a stuck sequence ends the run with a mismatch.
   task automatic wt(input int s, input int lim);
      int n;
      n = 0;
      while (sig(s) !== 1'b1) begin
         @(posedge clk_sys_i);
         #1;
         n++;
         if (n > lim) begin
            chk("wait", s, 32'hFF);
            test_done();
         end
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      wt(0, 200);
      chk("core", 32'h1, 32'(core_o));
      chk("ext_cfg", 32'h3, 32'(ext_o));
      chk("log2", 32'h3, 32'(log2_o));
      chk("src", 32'(RBCS_CLK_HALF), 32'(sel.src));
      chk("mode", 32'h1, 32'(mode_o));
      wt(1, 3000);
      chk("boot_sel", 32'hA, 32'(sel_o));
      rd(8'h08);
      chk("status", 32'h0A2F, rd_q);
      @(posedge clk_sys_i);
      #1;
      chk("rdata_idle", 32'h0, rdata);
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, i);
         chk("log2", 32'(1 + i[0] + i[1]), 32'(log2_o));
      end
      rd(8'h00);
      chk("ext_reg", 32'h3, rd_q);
      rd(8'h40);
      chk("unmapped", 32'h0, rd_q);
      wr(8'h04, 32'h3);
      repeat (20) @(posedge clk_sys_i);
      #1;
      chk("src", 32'(RBCS_CLK_HALF), 32'(sel.src));
      wt(3, 100);
      chk("pll_mul", 32'h3, 32'(sel.pll_mul));
      rd(8'h04);
      chk("pll_reg", 32'h3, rd_q);
      @(posedge clk_sys_i);
      wdog_req_i <= 1'b1;
      @(posedge clk_sys_i);
      wdog_req_i <= 1'b0;
      #1;
      chk("rst_out", 32'h0, 32'(rst_o));
      chk("core", 32'h0, 32'(core_o));
      wr(8'h00, 32'h0);
      repeat (98) @(posedge clk_sys_i);
      wdog_req_i <= 1'b1;
      @(posedge clk_sys_i);
      wdog_req_i <= 1'b0;
      wt(2, 600);
      wt(0, 200);
      chk("ext_cfg", 32'h3, 32'(ext_o));
      chk("pll_mul", 32'h0, 32'(sel.pll_mul));
      wt(1, 3000);
      chk("boot_sel", 32'hA, 32'(sel_o));
      @(posedge clk_sys_i);
      pll <= 1'b0;
      mode <= 1'b0;
      boot <= 4'h5;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      wt(4, 50);
      wt(0, 200);
      chk("src", 32'(RBCS_CLK_DIRECT), 32'(sel.src));
      chk("mode", 32'h0, 32'(mode_o));
      wr(8'h04, 32'h3);
      chk("pll_mul", 32'h0, 32'(sel.pll_mul));
      wt(1, 3000);
      chk("boot_sel", 32'h5, 32'(sel_o));
      test_done();
   end
endmodule
